// ---- bench/adcc_chk.sv ----
// Purpose: port-level checks of the async context control bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto adcc_top, sees its ports only
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        soft_reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [3:0]  ctx_run,
    input wire logic [3:0]  ctx_wake,
    input wire logic [3:0]  desc_fetch
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // nothing offered or held, so no register write can land next edge
    sequence s_wr_idle;
        s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
    endsequence

    chk_rd_latency: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer missing one cycle after address");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before taken");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before taken");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code outside okay and slave error");
    chk_reserved_field_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_6300) == 32'h0)
        else $error("reserved read bits not zero");
    chk_run_sw_only: assert property (!$stable(ctx_run) |-> $rose(s_axi_bvalid) || $past(soft_reset))
        else $error("run changed without a write or reset");
    chk_wake_rise: assert property (|(ctx_wake & ~$past(ctx_wake)) |-> $rose(s_axi_bvalid))
        else $error("wake set without a write");
    chk_wake_fetch: assert property (s_wr_idle ##0 (|desc_fetch) |=> (ctx_wake & $past(desc_fetch)) == 4'h0)
        else $error("wake not cleared by descriptor fetch");
endmodule : adcc_chk

bind adcc_top adcc_chk u_chk (.aclk, .aresetn, .soft_reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ctx_run, .ctx_wake, .desc_fetch);

`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: self-checking bench of the async context control bank
// Assumes: AXI4-Lite master tasks, ready sampled on the falling edge before the taking edge
// Notes:   every handshake wait is bounded
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.svh"

module tb;
    logic                aclk = 1'b0, aresetn = 1'b0, soft_reset = 1'b0;
    logic [`ADCC_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0]         s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]          s_axi_wstrb = '0;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic [3:0]          ctx_run, ctx_wake;
    logic [3:0]          desc_fetch = '0, fatal_err = '0, ctx_busy = '0, evt_valid = '0;
    logic [3:0][4:0]     evt_code = '0;
    logic [3:0][2:0]     evt_spd = '0;
    int                  error_cnt = 0, checked = 0;
    localparam logic [11:0] SA [4] = '{`ADCC_TXRQ_SET, `ADCC_TXRS_SET, `ADCC_RXRQ_SET, `ADCC_RXRS_SET};
    localparam logic [11:0] CA [4] = '{`ADCC_TXRQ_CLR, `ADCC_TXRS_CLR, `ADCC_RXRQ_CLR, `ADCC_RXRS_CLR};
    localparam logic [11:0] ST = `ADCC_INT_STATUS, MK = `ADCC_INT_MASK;
    localparam logic [1:0]  OK = `ADCC_RESP_OKAY, ER = `ADCC_RESP_SLVERR;
    localparam logic [31:0] RUN = 32'h0000_8000, WK = 32'h0000_1000, DD = 32'h0000_0800;
    localparam logic [31:0] AC = 32'h0000_0400;

    adcc_top dut (.aclk, .aresetn, .soft_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctx_run, .ctx_wake, .desc_fetch,
        .fatal_err, .ctx_busy, .evt_valid, .evt_code, .evt_spd, .irq);

    always #20 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic tmo(input logic ok);
        if (!ok) begin
            error_cnt++;
            $display("Error at %0t: handshake wait ran out", $time);
            close_out();
        end
    endtask : tmo

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic ta, tw, ka, kw, t;
        logic [1:0] r;
        ta = 0; tw = 0; t = 0; r = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        for (int n = 0; n < 20 && !(ta && tw); n++) begin
            @(negedge aclk); ka = s_axi_awvalid & s_axi_awready; kw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (ka) begin s_axi_awvalid <= 0; ta = 1; end
            if (kw) begin s_axi_wvalid <= 0; tw = 1; end
        end
        tmo(ta && tw);
        // bready rises on the same edge as bvalid, so the hold rule is not exercised here
        for (int n = 0; n < 20 && !t; n++) begin
            @(negedge aclk); t = s_axi_bvalid & s_axi_bready; r = s_axi_bresp;
            @(posedge aclk); s_axi_bready <= !t;
        end
        tmo(t);
        cmp({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic t;
        logic [31:0] g;
        logic [1:0] r;
        t = 0; g = 0; r = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        for (int n = 0; n < 20 && !t; n++) begin
            @(negedge aclk); t = s_axi_arready; @(posedge aclk);
        end
        tmo(t); s_axi_arvalid <= 0; t = 0;
        for (int n = 0; n < 20 && !t; n++) begin
            @(negedge aclk); t = s_axi_rvalid & s_axi_rready; g = s_axi_rdata; r = s_axi_rresp;
            @(posedge aclk); s_axi_rready <= !t;
        end
        tmo(t);
        cmp(g, ed);
        cmp({30'h0, r}, {30'h0, er});
    endtask : rd

    task automatic outs(input logic [3:0] er, input logic [3:0] ew, input logic ei);
        @(negedge aclk);
        cmp({23'h0, ctx_run, ctx_wake, irq}, {23'h0, er, ew, ei});
        @(posedge aclk);
    endtask : outs

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(SA[i], 32'h0, OK);
            rd(CA[i], 32'h0, OK);
        end
        rd(ST, 32'h0, OK);
        rd(MK, 32'h0, OK);
        outs(4'h0, 4'h0, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_setclr;
        for (int i = 0; i < 3; i++) begin
            wr(SA[i], RUN | WK, 4'h1, OK);
            rd(SA[i], 32'h0, OK);
            wr(SA[i], 32'hFFFF_FFFF, 4'hF, OK);
            rd(CA[i], RUN | WK, OK);
            outs(4'(1 << i), 4'(1 << i), 1'b0);
            wr(CA[i], WK, 4'hF, OK);
            rd(SA[i], RUN, OK);
            wr(CA[i], RUN, 4'hF, OK);
            rd(SA[i], 32'h0, OK);
        end
        wr(SA[3], RUN | WK, 4'hF, OK);
        rd(CA[3], RUN | WK, OK);
        outs(4'h8, 4'h8, 1'b0);
        wr(SA[3], 32'h0, 4'hF, OK);
        rd(SA[3], 32'h0, OK);
        $display("test set clear done");
    endtask : t_setclr

    task automatic t_wake;
        wr(SA[1], RUN | WK, 4'hF, OK);
        desc_fetch <= 4'h2;
        @(posedge aclk);
        desc_fetch <= 4'h0;
        rd(SA[1], RUN, OK);
        outs(4'h2, 4'h0, 1'b0);
        wr(CA[1], RUN, 4'hF, OK);
        $display("test wake done");
    endtask : t_wake

    task automatic t_dead;
        wr(MK, 32'h4, 4'h1, OK);
        wr(SA[2], RUN, 4'hF, OK);
        fatal_err <= 4'h4;
        @(posedge aclk);
        fatal_err <= 4'h0;
        rd(SA[2], RUN | DD, OK);
        outs(4'h4, 4'h0, 1'b1);
        wr(CA[2], RUN, 4'hF, OK);
        rd(SA[2], 32'h0, OK);
        rd(ST, 32'h4, OK);
        wr(ST, 32'h4, 4'h1, OK);
        outs(4'h0, 4'h0, 1'b0);
        rd(ST, 32'h0, OK);
        $display("test dead done");
    endtask : t_dead

    task automatic t_evt;
        wr(SA[2], RUN, 4'hF, OK);
        ctx_busy <= 4'h5;
        // every documented speed code on a receive context
        for (int k = 0; k < 3; k++) begin
            evt_code[2] <= 5'(5'h10 + k); evt_spd[2] <= 3'(k); evt_valid <= 4'h4;
            @(posedge aclk);
            evt_valid <= 4'h0;
            rd(SA[2], RUN | AC | 32'(k << 5) | 32'(5'h10 + k), OK);
        end
        wr(SA[0], RUN, 4'hF, OK);
        evt_code[0] <= 5'h0B; evt_spd[0] <= 3'h2; evt_valid <= 4'h1;
        @(posedge aclk);
        evt_valid <= 4'h0;
        rd(SA[0], RUN | AC | 32'h0B, OK);
        wr(CA[2], RUN, 4'hF, OK);
        rd(SA[2], 32'h52, OK);
        rd(ST, 32'h50, OK);
        outs(4'h1, 4'h0, 1'b0);
        wr(ST, 32'h50, 4'h1, OK);
        wr(CA[0], RUN, 4'hF, OK);
        ctx_busy <= 4'h0;
        $display("test event done");
    endtask : t_evt

    task automatic t_unmapped;
        rd(12'h100, 32'h0, ER);
        wr(12'h100, 32'hFFFF_FFFF, 4'hF, ER);
        outs(4'h0, 4'h0, 1'b0);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_soft;
        wr(SA[0], RUN | WK, 4'hF, OK);
        wr(MK, 32'hFF, 4'h1, OK);
        // pending status and dead bit must also fall to the software reset
        fatal_err <= 4'h1;
        @(posedge aclk);
        fatal_err <= 4'h0;
        outs(4'h1, 4'h1, 1'b1);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        outs(4'h0, 4'h0, 1'b0);
        rd(SA[0], 32'h0, OK);
        rd(MK, 32'h0, OK);
        rd(ST, 32'h0, OK);
        $display("test soft reset done");
    endtask : t_soft

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_setclr();
        t_wake();
        t_dead();
        t_evt();
        t_unmapped();
        t_soft();
        close_out();
    end
endmodule : tb

`default_nettype wire

// ---- logic/adcc_ctx.sv ----
// Purpose: control and status state of one asynchronous context
// Assumes: engine strobes are one-cycle pulses, busy is a level
// Notes:   software set beats a same-cycle hardware clear
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_ctx #(
    parameter bit IS_RX = 1'b0
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       soft_reset,
    adcc_ctx_if.ctx         regs,
    input  wire logic       desc_fetch,
    input  wire logic       fatal_err,
    input  wire logic       busy,
    input  wire logic       evt_valid,
    input  wire logic [4:0] evt_code,
    input  wire logic [2:0] evt_spd
);
    import adcc_pkg::*;

    typedef struct packed {
        adcc_ctl_t ctl;
    } adcc_ctx_state_t;

    adcc_ctx_state_t st_reg;
    adcc_ctx_state_t st_next;

    always_comb begin
        logic [15:0] s;
        logic [15:0] c;
        s = regs.wbits & regs.wmask;
        c = ~regs.wbits & regs.wmask;
        st_next = st_reg;
        if (desc_fetch) begin
            st_next.ctl.wake = 1'b0;
        end
        if (regs.set_we || regs.ld_we) begin
            if (s[`ADCC_RUN_BIT]) st_next.ctl.run = 1'b1;
            if (s[`ADCC_WAKE_BIT]) st_next.ctl.wake = 1'b1;
        end
        if (regs.clr_we && s[`ADCC_RUN_BIT]) st_next.ctl.run = 1'b0;
        if (regs.clr_we && s[`ADCC_WAKE_BIT]) st_next.ctl.wake = 1'b0;
        // shared set/clear address: zeros written in enabled lanes clear
        if (regs.ld_we && c[`ADCC_RUN_BIT]) st_next.ctl.run = 1'b0;
        if (regs.ld_we && c[`ADCC_WAKE_BIT] && !desc_fetch) st_next.ctl.wake = 1'b0;
        if (st_reg.ctl.run && !st_next.ctl.run) begin
            st_next.ctl.dead = 1'b0;
        end
        if (fatal_err) begin
            st_next.ctl.dead = 1'b1;
        end
        st_next.ctl.active = busy && st_next.ctl.run;
        if (evt_valid) begin
            st_next.ctl.evt = evt_code;
            st_next.ctl.spd = IS_RX ? evt_spd : 3'h0;
        end
        if (soft_reset) begin
            st_next = '0;
        end
    end

    // run changes only through software writes or soft_reset above, or reset here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regs.ctl       = st_reg.ctl;
    assign regs.fatal_evt = fatal_err;
    assign regs.done_evt  = evt_valid;

endmodule : adcc_ctx

`default_nettype wire

// ---- logic/adcc_ctx_if.sv ----
// Purpose: register access path from the bank to one context
// Assumes: one clock, write strobes are single-cycle pulses
// Notes:   wmask marks bits whose byte lane was enabled
`timescale 1ns/100ps
`default_nettype none

interface adcc_ctx_if;
    import adcc_pkg::*;
    logic              set_we;
    logic              clr_we;
    logic              ld_we;
    logic [15:0]       wbits;
    logic [15:0]       wmask;
    adcc_pkg::adcc_ctl_t ctl;
    logic              fatal_evt;
    logic              done_evt;

    modport bank (output set_we, clr_we, ld_we, wbits, wmask,
                  input  ctl, fatal_evt, done_evt);
    modport ctx  (input  set_we, clr_we, ld_we, wbits, wmask,
                  output ctl, fatal_evt, done_evt);
endinterface : adcc_ctx_if

`default_nettype wire

// ---- logic/adcc_defs.svh ----
// Purpose: offsets, field positions, reset values of the async context control bank
// Assumes: 12-bit byte address inside the controller window
// Notes:   definitions only
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_AW            12
`define ADCC_TXRQ_SET      12'h180
`define ADCC_TXRQ_CLR      12'h184
`define ADCC_TXRS_SET      12'h1A0
`define ADCC_TXRS_CLR      12'h1A4
`define ADCC_RXRQ_SET      12'h1C0
`define ADCC_RXRQ_CLR      12'h1C4
`define ADCC_RXRS_SET      12'h1E4
`define ADCC_RXRS_CLR      12'h1E4
`define ADCC_INT_STATUS    12'h1F0
`define ADCC_INT_MASK      12'h1F4

`define ADCC_RUN_BIT       15
`define ADCC_WAKE_BIT      12
`define ADCC_DEAD_BIT      11
`define ADCC_ACTIVE_BIT    10
`define ADCC_SPD_LSB       5
`define ADCC_EVT_LSB       0
`define ADCC_INT_DONE_LSB  4

`define ADCC_CTL_RESET     16'h0000
`define ADCC_INT_RESET     8'h00
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2

`endif

// ---- logic/adcc_pkg.sv ----
// Purpose: types shared by the async context control bank
// Assumes: adcc_defs.svh holds the numbers
// Notes:   word packing lives here so bank and context agree
`include "adcc_defs.svh"

package adcc_pkg;

    typedef struct packed {
        logic       run;
        logic       wake;
        logic       dead;
        logic       active;
        logic [2:0] spd;
        logic [4:0] evt;
    } adcc_ctl_t;

    typedef struct packed {
        logic       ctx_hit;
        logic [1:0] idx;
        logic       is_set;
        logic       is_clr;
        logic       sts_hit;
        logic       msk_hit;
    } adcc_dec_t;

    function automatic logic [31:0] adcc_ctl_word(adcc_ctl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`ADCC_RUN_BIT]                   = c.run;
        w[`ADCC_WAKE_BIT]                  = c.wake;
        w[`ADCC_DEAD_BIT]                  = c.dead;
        w[`ADCC_ACTIVE_BIT]                = c.active;
        w[`ADCC_SPD_LSB +: 3]              = c.spd;
        w[`ADCC_EVT_LSB +: 5]              = c.evt;
        return w;
    endfunction : adcc_ctl_word

endpackage : adcc_pkg

// ---- logic/adcc_top.sv ----
// Purpose: AXI4-Lite register bank for the four async DMA contexts
// Assumes: 12-bit byte addresses, one outstanding read and write
// Notes:   interrupt status is write-one-to-clear, hardware set wins
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  soft_reset,
    input  wire logic [`ADCC_AW-1:0]   s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [`ADCC_AW-1:0]   s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [3:0]                 ctx_run,
    output logic [3:0]                 ctx_wake,
    input  wire logic [3:0]            desc_fetch,
    input  wire logic [3:0]            fatal_err,
    input  wire logic [3:0]            ctx_busy,
    input  wire logic [3:0]            evt_valid,
    input  wire logic [3:0][4:0]       evt_code,
    input  wire logic [3:0][2:0]       evt_spd,
    output logic                       irq
);
    import adcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [`ADCC_AW-1:0] SET_OFF [4] = '{`ADCC_TXRQ_SET, `ADCC_TXRS_SET,
                                                   `ADCC_RXRQ_SET, `ADCC_RXRS_SET};
    localparam logic [`ADCC_AW-1:0] CLR_OFF [4] = '{`ADCC_TXRQ_CLR, `ADCC_TXRS_CLR,
                                                   `ADCC_RXRQ_CLR, `ADCC_RXRS_CLR};

    typedef struct packed {
        logic                aw_full;
        logic [`ADCC_AW-1:0] aw_addr;
        logic                w_full;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [7:0]          int_status;
        logic [7:0]          int_mask;
        logic                irq;
    } adcc_top_state_t;

    adcc_top_state_t st_reg;
    adcc_top_state_t st_next;

    // one decoder for both channels keeps read and write maps identical
    function automatic adcc_dec_t adcc_decode(logic [`ADCC_AW-1:0] a);
        adcc_dec_t d;
        d = '0;
        for (int i = 0; i < 4; i++) begin
            if (a == SET_OFF[i]) begin
                d.ctx_hit = 1'b1;
                d.idx     = 2'(i);
                d.is_set  = 1'b1;
            end
            if (a == CLR_OFF[i]) begin
                d.ctx_hit = 1'b1;
                d.idx     = 2'(i);
                d.is_clr  = 1'b1;
            end
        end
        d.sts_hit = (a == `ADCC_INT_STATUS);
        d.msk_hit = (a == `ADCC_INT_MASK);
        return d;
    endfunction : adcc_decode

    ////////////////////////////////////////////////////////////////////////////
    adcc_ctx_if cif[4] ();
    adcc_ctl_t  ctl_v [4];
    logic [3:0] fatal_v;
    logic [3:0] done_v;
    adcc_dec_t  wdec;
    adcc_dec_t  rdec;
    logic       wr_go;
    logic [31:0] wmask32;

    assign wdec  = adcc_decode(st_reg.aw_addr);
    assign rdec  = adcc_decode(s_axi_araddr);
    assign wr_go = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    assign wmask32 = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}},
                      {8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};

    for (genvar g = 0; g < 4; g++) begin : g_ctx
        logic hit;
        assign hit              = wr_go && wdec.ctx_hit && (wdec.idx == 2'(g));
        assign cif[g].set_we    = hit && wdec.is_set && !wdec.is_clr;
        assign cif[g].clr_we    = hit && wdec.is_clr && !wdec.is_set;
        assign cif[g].ld_we     = hit && wdec.is_set && wdec.is_clr;
        assign cif[g].wbits     = st_reg.w_data[15:0];
        assign cif[g].wmask     = wmask32[15:0];
        assign ctl_v[g]         = cif[g].ctl;
        assign fatal_v[g]       = cif[g].fatal_evt;
        assign done_v[g]        = cif[g].done_evt;
        assign ctx_run[g]       = cif[g].ctl.run;
        assign ctx_wake[g]      = cif[g].ctl.wake;

        adcc_ctx #(
            .IS_RX (g >= 2)
        ) u_ctx (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .soft_reset (soft_reset),
            .regs       (cif[g]),
            .desc_fetch (desc_fetch[g]),
            .fatal_err  (fatal_err[g]),
            .busy       (ctx_busy[g]),
            .evt_valid  (evt_valid[g]),
            .evt_code   (evt_code[g]),
            .evt_spd    (evt_spd[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = !st_reg.aw_full;
    assign s_axi_wready  = !st_reg.w_full;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign irq           = st_reg.irq;

    always_comb begin
        logic [7:0] w1c;
        w1c = 8'h00;
        st_next = st_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_full = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = (wdec.ctx_hit || wdec.sts_hit || wdec.msk_hit)
                              ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            if (wdec.msk_hit && st_reg.w_strb[0]) begin
                st_next.int_mask = st_reg.w_data[7:0];
            end
            if (wdec.sts_hit && st_reg.w_strb[0]) begin
                w1c = st_reg.w_data[7:0];
            end
        end

        // a hardware event in the clearing cycle survives the clear
        st_next.int_status = (st_reg.int_status & ~w1c) | {done_v, fatal_v};
        if (soft_reset) begin
            st_next.int_status = `ADCC_INT_RESET;
            st_next.int_mask   = `ADCC_INT_RESET;
        end
        st_next.irq = |(st_next.int_status & st_next.int_mask);

        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = `ADCC_RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            if (rdec.ctx_hit) begin
                // packing leaves 31:16, 14:13 and 9:8 at zero
                st_next.rdata = adcc_ctl_word(ctl_v[rdec.idx]);
            end else if (rdec.sts_hit) begin
                st_next.rdata[7:0] = st_reg.int_status;
            end else if (rdec.msk_hit) begin
                st_next.rdata[7:0] = st_reg.int_mask;
            end else begin
                st_next.rresp = `ADCC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : adcc_top

`default_nettype wire
